/* File: rtl/ccm_pkg.sv */
// Package with register map, mode codes and field layout of the mode control
package ccm_pkg;

   // =========================================================
   // Register offsets (4-bit register port address)
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_DUTY_HIGH = 4'h1;
   localparam logic [3:0] ADDR_COMPARE_LO = 4'h2;
   localparam logic [3:0] ADDR_COMPARE_HI = 4'h3;
   localparam logic [3:0] ADDR_CAPTURE_LO = 4'h4;
   localparam logic [3:0] ADDR_CAPTURE_HI = 4'h5;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;

   // =========================================================
   // Control register layout
   localparam int MODE_LSB = 0;
   localparam int DUTY_LOW_LSB = 4;
   localparam logic [7:0] CONTROL_IMPL_MASK = 8'h3F;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // =========================================================
   // Interrupt status bits
   localparam int IRQ_MATCH_CAPTURE = 0;
   localparam int IRQ_SPECIAL = 1;
   localparam int IRQ_WIDTH = 2;

   // =========================================================
   // Mode field encodings
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_TOGGLE = 4'h2;
   localparam logic [3:0] MODE_CAN_CAPTURE = 4'h3;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_SET_HIGH = 4'h8;
   localparam logic [3:0] MODE_SET_LOW = 4'h9;
   localparam logic [3:0] MODE_SOFT_IRQ = 4'hA;
   localparam logic [3:0] MODE_SPECIAL = 4'hB;
   localparam logic [1:0] MODE_PWM_TOP = 2'h3;

   // =========================================================
   // Prescale terminal counts
   localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
   localparam logic [3:0] PRESCALE_16_LAST = 4'hF;
   localparam logic [3:0] PRESCALE_ZERO = 4'h0;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic write;
      logic read;
   } ccm_req_s;

endpackage : ccm_pkg

/* File: rtl/ccm_edge_prescale.sv */
// Pin edge detector with capture prescaler
`timescale 1ns/1ps
`default_nettype none
module ccm_edge_prescale (
   // Clock and reset
   input wire logic clk,
   input wire logic rstN,
   // Control
   input wire logic clear,
   input wire logic [3:0] lastCount,
   input wire logic useFalling,
   input wire logic enable,
   // Pin sample and result
   input wire logic pinIn,
   output logic fire
);

   logic pinPrev;
   logic [3:0] count;
   logic edgeSeen;

   // Previous pin sample
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         pinPrev <= 1'b0;
      end else begin
         pinPrev <= pinIn;
      end
   end

   assign edgeSeen = enable &&
      (useFalling ? (pinPrev && !pinIn) : (!pinPrev && pinIn));

   // Edge counter; fires on the last counted edge
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         count <= ccm_pkg::PRESCALE_ZERO;
      end else if (clear) begin
         count <= ccm_pkg::PRESCALE_ZERO;
      end else if (edgeSeen) begin
         if (count == lastCount) begin
            count <= ccm_pkg::PRESCALE_ZERO;
         end else begin
            count <= count + 4'h1;
         end
      end
   end

   assign fire = edgeSeen && (count == lastCount);

endmodule : ccm_edge_prescale
`default_nettype wire

/* File: rtl/ccm_mode_control.sv */
// Capture/compare/PWM mode control with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
// Function
// - In PWM mode the two duty low bits form bits 1:0 of duty.
// - Duty bits 9:2 come from the duty high register, above low bits.
// - Mode 0000 turns unit off and clears its pin, match and prescaler state; capture and flags are kept.
// - Mode 0010 toggles pin on each compare match and sets flag.
// - Mode 0011 captures on CAN message received, first unit only.
// - Mode 0100 captures on every falling pin edge.
// - Mode 0101 captures on every rising pin edge.
// - Mode 0110 captures on every fourth rising pin edge.
// - Mode 0111 captures on every sixteenth rising pin edge.
// - Mode 1000 drives pin low on entry, high on match, sets flag.
// - Mode 1001 drives pin high on entry, low on match, sets flag.
// - Mode 1010 sets flag on match, pin left unchanged.
// - Mode 1011 sets flag and emits special-event timer reset on match.
// - Unimplemented control bits read back as zero.
module ccm_mode_control #(
   parameter bit FIRST_UNIT = 1'b1,
   parameter int TIMER_WIDTH = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regReadData,
   // Timer and events
   input wire logic [TIMER_WIDTH-1:0] timerValue,
   input wire logic canReceived,
   // Capture/compare pin
   input wire logic pinIn,
   output logic pinOut,
   output logic pinOe,
   // Results
   output logic [9:0] pwmDuty,
   output logic pwmEnable,
   output logic specialTrigger,
   output logic matchCapturePulse,
   output logic irq
);

   // =========================================================
   // Reset synchroniser
   logic rstMeta;
   logic rstN;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN <= rstMeta;
      end
   end

   // =========================================================
   // Registers
   ccm_pkg::ccm_req_s req;
   logic [7:0] control;
   logic [7:0] dutyHigh;
   logic [TIMER_WIDTH-1:0] compareValue;
   logic [TIMER_WIDTH-1:0] captureValue;
   logic [ccm_pkg::IRQ_WIDTH-1:0] irqStatus;
   logic [ccm_pkg::IRQ_WIDTH-1:0] irqMask;
   logic [3:0] mode;
   logic [3:0] prevMode;
   logic modeChanged;
   logic compareMatch;
   logic matchPrev;
   logic matchEvent;
   logic captureEvent;
   logic prescaleFire;
   logic [3:0] prescaleLast;
   logic isCapture;
   logic isPwm;
   logic [ccm_pkg::IRQ_WIDTH-1:0] irqSet;

   assign req = '{addr: regAddr, wdata: regWriteData,
                  write: regWrite, read: regRead};
   assign mode = control[ccm_pkg::MODE_LSB +: 4];
   assign modeChanged = (mode != prevMode);
   assign isPwm = (mode[3:2] == ccm_pkg::MODE_PWM_TOP);

   // Control register; only implemented bits stored
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         control <= ccm_pkg::CONTROL_RESET;
      end else if (req.write && req.addr == ccm_pkg::ADDR_CONTROL) begin
         control <= req.wdata & ccm_pkg::CONTROL_IMPL_MASK;
      end
   end

   // Duty high and compare value registers
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         dutyHigh <= ccm_pkg::BYTE_ZERO;
         compareValue <= '0;
      end else if (req.write) begin
         case (req.addr)
            ccm_pkg::ADDR_DUTY_HIGH: dutyHigh <= req.wdata;
            ccm_pkg::ADDR_COMPARE_LO: compareValue[7:0] <= req.wdata;
            ccm_pkg::ADDR_COMPARE_HI: begin
               compareValue[TIMER_WIDTH-1:8] <=
                  req.wdata[TIMER_WIDTH-9:0];
            end
            default: ;
         endcase
      end
   end

   // Mode history for entry detection
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         prevMode <= ccm_pkg::MODE_OFF;
      end else begin
         prevMode <= mode;
      end
   end

   // =========================================================
   // Compare match, one event per new match
   assign compareMatch = (timerValue == compareValue);

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         matchPrev <= 1'b0;
      end else if (mode == ccm_pkg::MODE_OFF) begin
         matchPrev <= 1'b0;
      end else begin
         matchPrev <= compareMatch;
      end
   end

   // Compare modes are 0010 and 1000..1011
   assign matchEvent = compareMatch && !matchPrev && !modeChanged &&
      (mode == ccm_pkg::MODE_TOGGLE || mode == ccm_pkg::MODE_SET_HIGH ||
       mode == ccm_pkg::MODE_SET_LOW || mode == ccm_pkg::MODE_SOFT_IRQ ||
       mode == ccm_pkg::MODE_SPECIAL);

   // =========================================================
   // Capture event sources
   assign isCapture = (mode >= ccm_pkg::MODE_CAP_FALL) &&
                      (mode <= ccm_pkg::MODE_CAP_RISE16);
   assign prescaleLast =
      (mode == ccm_pkg::MODE_CAP_RISE4) ? ccm_pkg::PRESCALE_4_LAST :
      (mode == ccm_pkg::MODE_CAP_RISE16) ? ccm_pkg::PRESCALE_16_LAST :
      ccm_pkg::PRESCALE_ZERO;

   ccm_edge_prescale u_prescale (
      .clk(core_clk),
      .rstN(rstN),
      .clear(modeChanged || mode == ccm_pkg::MODE_OFF),
      .lastCount(prescaleLast),
      .useFalling(mode == ccm_pkg::MODE_CAP_FALL),
      .enable(isCapture),
      .pinIn(pinIn),
      .fire(prescaleFire)
   );

   assign captureEvent = prescaleFire ||
      (FIRST_UNIT && mode == ccm_pkg::MODE_CAN_CAPTURE &&
       canReceived);

   // Capture register
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         captureValue <= '0;
      end else if (captureEvent) begin
         captureValue <= timerValue;
      end
   end

   // =========================================================
   // Pin drive
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         pinOut <= 1'b0;
      end else if (mode == ccm_pkg::MODE_OFF) begin
         pinOut <= 1'b0;
      end else if (modeChanged && mode == ccm_pkg::MODE_SET_HIGH) begin
         pinOut <= 1'b0;
      end else if (modeChanged && mode == ccm_pkg::MODE_SET_LOW) begin
         pinOut <= 1'b1;
      end else if (matchEvent) begin
         case (mode)
            ccm_pkg::MODE_TOGGLE: pinOut <= !pinOut;
            ccm_pkg::MODE_SET_HIGH: pinOut <= 1'b1;
            ccm_pkg::MODE_SET_LOW: pinOut <= 1'b0;
            default: pinOut <= pinOut;
         endcase
      end
   end

   // Drive pin in compare modes that own it
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         pinOe <= 1'b0;
      end else begin
         pinOe <= (mode == ccm_pkg::MODE_TOGGLE ||
                   mode == ccm_pkg::MODE_SET_HIGH ||
                   mode == ccm_pkg::MODE_SET_LOW);
      end
   end

   // =========================================================
   // Event pulses
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         specialTrigger <= 1'b0;
         matchCapturePulse <= 1'b0;
      end else begin
         specialTrigger <= matchEvent &&
            (mode == ccm_pkg::MODE_SPECIAL);
         matchCapturePulse <= matchEvent || captureEvent;
      end
   end

   // PWM duty assembly
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         pwmDuty <= 10'h000;
         pwmEnable <= 1'b0;
      end else begin
         pwmDuty <= {dutyHigh,
                     control[ccm_pkg::DUTY_LOW_LSB +: 2]};
         pwmEnable <= isPwm;
      end
   end

   // =========================================================
   // Interrupt status, write one to clear, set wins
   assign irqSet[ccm_pkg::IRQ_MATCH_CAPTURE] = matchEvent || captureEvent;
   assign irqSet[ccm_pkg::IRQ_SPECIAL] =
      matchEvent && (mode == ccm_pkg::MODE_SPECIAL);

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         irqStatus <= '0;
      end else begin
         if (req.write && req.addr == ccm_pkg::ADDR_IRQ_STATUS) begin
            irqStatus <= (irqStatus & ~req.wdata[ccm_pkg::IRQ_WIDTH-1:0])
                         | irqSet;
         end else begin
            irqStatus <= irqStatus | irqSet;
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         irqMask <= '0;
      end else if (req.write && req.addr == ccm_pkg::ADDR_IRQ_MASK) begin
         irqMask <= req.wdata[ccm_pkg::IRQ_WIDTH-1:0];
      end
   end

   assign irq = |(irqStatus & irqMask);

   // =========================================================
   // Read data, one cycle after the strobe
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         regReadData <= ccm_pkg::BYTE_ZERO;
      end else if (req.read) begin
         case (req.addr)
            ccm_pkg::ADDR_CONTROL: begin
               regReadData <= control & ccm_pkg::CONTROL_IMPL_MASK;
            end
            ccm_pkg::ADDR_DUTY_HIGH: regReadData <= dutyHigh;
            ccm_pkg::ADDR_COMPARE_LO: regReadData <= compareValue[7:0];
            ccm_pkg::ADDR_COMPARE_HI: begin
               regReadData <= compareValue[TIMER_WIDTH-1:8];
            end
            ccm_pkg::ADDR_CAPTURE_LO: regReadData <= captureValue[7:0];
            ccm_pkg::ADDR_CAPTURE_HI: begin
               regReadData <= captureValue[TIMER_WIDTH-1:8];
            end
            ccm_pkg::ADDR_IRQ_STATUS: begin
               regReadData <= {6'h00, irqStatus};
            end
            ccm_pkg::ADDR_IRQ_MASK: regReadData <= {6'h00, irqMask};
            default: regReadData <= ccm_pkg::BYTE_ZERO;
         endcase
      end else begin
         regReadData <= ccm_pkg::BYTE_ZERO;
      end
   end

endmodule : ccm_mode_control
`default_nettype wire

/* File: verif/ccm_mode_control_props.sv */
// Port checker for the capture/compare mode control
`timescale 1ns/1ps
`default_nettype none
module ccm_mode_control_props (
   // Clock, reset and register port
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regReadData,
   // Pin and results
   input wire logic pinOut,
   input wire logic pinOe,
   input wire logic [9:0] pwmDuty,
   input wire logic pwmEnable,
   input wire logic specialTrigger,
   input wire logic matchCapturePulse
);
   // =========================================================
   // Mode tracked from control writes
   logic [3:0] ctlMode;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctlMode <= 4'h0;
      end else if (regWrite && regAddr == ccm_pkg::ADDR_CONTROL) begin
         ctlMode <= regWriteData[3:0];
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // =========================================================
   // Sequences: control write, mode settled for two cycles
   sequence s_ctlWr;
      regWrite && regAddr == ccm_pkg::ADDR_CONTROL;
   endsequence
   sequence s_held(md);
      ctlMode == md && $past(ctlMode, 2) == md;
   endsequence
   // =========================================================
   // Properties
   property p_ctlRsv;
      $past(regRead) && $past(regAddr) == ccm_pkg::ADDR_CONTROL
         |-> regReadData[7:6] == 2'h0;
   endproperty
   a_ctlRsv: assert property (p_ctlRsv) else $error("ctl rsv");
   property p_dutyLow;
      s_ctlWr |-> ##2 pwmDuty[1:0] == $past(regWriteData[5:4], 2);
   endproperty
   a_dutyLow: assert property (p_dutyLow) else $error("duty lo");
   property p_dutyHigh;
      regWrite && regAddr == ccm_pkg::ADDR_DUTY_HIGH
         |-> ##2 pwmDuty[9:2] == $past(regWriteData, 2);
   endproperty
   a_dutyHigh: assert property (p_dutyHigh) else $error("duty hi");
   property p_pwmOn;
      s_ctlWr |-> ##2 pwmEnable == ($past(regWriteData[3:2], 2) == 2'h3);
   endproperty
   a_pwmOn: assert property (p_pwmOn) else $error("pwm en");
   property p_off;
      s_ctlWr ##0 regWriteData[3:0] == ccm_pkg::MODE_OFF
         |-> ##2 !pinOut && !pinOe;
   endproperty
   a_off: assert property (p_off) else $error("off pin");
   property p_toggle;
      s_held(ccm_pkg::MODE_TOGGLE) ##0 matchCapturePulse
         |-> pinOut != $past(pinOut);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle");
   property p_setHigh;
      s_held(ccm_pkg::MODE_SET_HIGH) ##0 matchCapturePulse
         |-> pinOut && pinOe;
   endproperty
   a_setHigh: assert property (p_setHigh) else $error("set hi");
   property p_trig;
      specialTrigger |-> $past(ctlMode) == ccm_pkg::MODE_SPECIAL
         && matchCapturePulse ##1 !specialTrigger;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger");
endmodule : ccm_mode_control_props
bind ccm_mode_control ccm_mode_control_props u_props (
   .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
   .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
   .regReadData(regReadData), .pinOut(pinOut), .pinOe(pinOe),
   .pwmDuty(pwmDuty), .pwmEnable(pwmEnable),
   .specialTrigger(specialTrigger), .matchCapturePulse(matchCapturePulse)
);
`default_nettype wire

/* File: verif/ccm_pin_model.sv */
// External source and load on the capture/compare pin
`timescale 1ns/1ps
`default_nettype none
module ccm_pin_model (
   // Unit side
   input wire logic pinOut,
   input wire logic pinOe,
   // Source level and resolved pin
   input wire logic srcLevel,
   output logic pinIn
);
   // Unit wins while it drives, the source otherwise
   assign pinIn = pinOe ? pinOut : srcLevel;
endmodule : ccm_pin_model
`default_nettype wire

/* File: verif/tb_ccm_mode_control.sv */
// Self-checking bench for the capture/compare mode control
`timescale 1ns/1ps
`default_nettype none
module tb_ccm_mode_control;
   // =========================================================
   // Signals and bookkeeping
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWriteData = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [15:0] timerValue = 16'h0000;
   logic canReceived = 1'b0;
   logic srcLevel = 1'b0;
   logic pinIn, pinOut, pinOe, pwmEnable, specialTrigger, irq, pv;
   logic matchCapturePulse;
   logic [7:0] regReadData, rdv, d, h;
   logic [9:0] pwmDuty;
   logic [3:0] m;
   logic [3:0] cmpModes [5] = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
   int fails = 0;
   int n_tests = 0;
   int pulses = 0;
   int seed = 32'h5026;
   // Clock and pulse counter
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) if (matchCapturePulse === 1'b1) pulses <= pulses + 1;
   // Design and pin partner
   ccm_mode_control #(.FIRST_UNIT(1'b1), .TIMER_WIDTH(16)) uut (
      .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
      .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
      .regReadData(regReadData), .timerValue(timerValue),
      .canReceived(canReceived), .pinIn(pinIn), .pinOut(pinOut),
      .pinOe(pinOe), .pwmDuty(pwmDuty), .pwmEnable(pwmEnable),
      .specialTrigger(specialTrigger),
      .matchCapturePulse(matchCapturePulse), .irq(irq)
   );
   ccm_pin_model u_pin (
      .pinOut(pinOut), .pinOe(pinOe), .srcLevel(srcLevel), .pinIn(pinIn)
   );
   // =========================================================
   // Tasks and expectations
   task automatic check(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk);
      regAddr <= a;
      regWriteData <= v;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 v = regReadData;
   endtask : rd
   function automatic logic expPin(input logic [3:0] md, input logic p);
      case (md)
         4'h2: return ~p;
         4'h8: return 1'b1;
         4'h9: return 1'b0;
         default: return p;
      endcase
   endfunction : expPin
   // 36 pin steps, rises at even steps, timer 0x100 plus step
   function automatic logic [15:0] expCap(input logic [3:0] md);
      case (md)
         4'h4: return 16'h0123;
         4'h5: return 16'h0122;
         default: return 16'h011E;
      endcase
   endfunction : expCap
   function automatic logic [15:0] expCount(input logic [3:0] md);
      return (md == 4'h7) ? 16'h1 : (md == 4'h6) ? 16'h4 : 16'h12;
   endfunction : expCount
   task automatic print_verdict;
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   // =========================================================
   // Watchdog
   initial begin
      repeat (100000) @(posedge core_clk);
      fails++;
      print_verdict();
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(ccm_pkg::ADDR_CONTROL, rdv);
      check(16'(rdv), 16'h0);
      rd(4'h8, rdv);
      check(16'(rdv), 16'h0);
      // Random control and duty values, all ones first
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'hFF : 8'($random(seed));
         h = (i == 0) ? 8'hFF : 8'($random(seed));
         wr(ccm_pkg::ADDR_CONTROL, d);
         wr(ccm_pkg::ADDR_DUTY_HIGH, h);
         rd(ccm_pkg::ADDR_CONTROL, rdv);
         check(16'(rdv), 16'(d & 8'h3F));
         check(16'(pwmDuty), 16'({h, d[5:4]}));
         check(16'(pwmEnable), 16'(d[3:2] == 2'h3));
      end
      wr(ccm_pkg::ADDR_CONTROL, 8'h00);
      wr(ccm_pkg::ADDR_COMPARE_LO, 8'h34);
      wr(ccm_pkg::ADDR_COMPARE_HI, 8'h12);
      // Compare modes: entry level, match, flag, mask, clear
      foreach (cmpModes[k]) begin
         m = cmpModes[k];
         wr(ccm_pkg::ADDR_IRQ_MASK, {7'h0, m != 4'hA});
         wr(ccm_pkg::ADDR_CONTROL, {4'h0, m});
         repeat (3) @(posedge core_clk);
         #1 pv = pinOut;
         check(16'(pv), 16'(m == 4'h9));
         @(posedge core_clk);
         timerValue <= 16'h1234;
         @(posedge core_clk);
         timerValue <= 16'h0000;
         #1 check(16'(matchCapturePulse), 16'h1);
         check(16'(specialTrigger), 16'(m == 4'hB));
         check(16'(pinOut), 16'(expPin(m, pv)));
         check(16'(irq), 16'(m != 4'hA));
         rd(ccm_pkg::ADDR_IRQ_STATUS, rdv);
         check(16'(rdv), 16'({m == 4'hB, 1'b1}));
         wr(ccm_pkg::ADDR_IRQ_STATUS, 8'h03);
         check(16'(irq), 16'h0);
         wr(ccm_pkg::ADDR_CONTROL, 8'h00);
         repeat (2) @(posedge core_clk);
         #1 check(16'({pinOut, pinOe}), 16'h0);
      end
      // Capture modes, switched directly so the prescaler must restart
      for (int k = 7; k >= 4; k--) begin
         m = 4'(k);
         wr(ccm_pkg::ADDR_CONTROL, {4'h0, m});
         pulses = 0;
         for (int j = 0; j < 36; j++) begin
            @(posedge core_clk);
            srcLevel <= ~srcLevel;
            timerValue <= 16'h0100 + 16'(j);
            repeat (3) @(posedge core_clk);
         end
         repeat (3) @(posedge core_clk);
         #1 check(16'(pulses), expCount(m));
         rd(ccm_pkg::ADDR_CAPTURE_LO, rdv);
         rd(ccm_pkg::ADDR_CAPTURE_HI, h);
         check({h, rdv}, expCap(m));
      end
      // Capture on a received message
      wr(ccm_pkg::ADDR_CONTROL, 8'h03);
      @(posedge core_clk);
      timerValue <= 16'h0ABC;
      canReceived <= 1'b1;
      @(posedge core_clk);
      canReceived <= 1'b0;
      rd(ccm_pkg::ADDR_CAPTURE_LO, rdv);
      rd(ccm_pkg::ADDR_CAPTURE_HI, h);
      check({h, rdv}, 16'h0ABC);
      print_verdict();
   end
endmodule : tb_ccm_mode_control
`default_nettype wire
